// File: cep_params.svh
`ifndef CEP_PARAMS_SVH
`define CEP_PARAMS_SVH

// ****************************************************************
// cause vector shape
// ****************************************************************
`define CEP_NUM_CAUSES 21
`define CEP_CAUSE_W 5

// ****************************************************************
// default widths of the request ports
// ****************************************************************
`define CEP_IRQ_W 8
`define CEP_COP_N 4
`define CEP_COP_SEL_W 2

// ****************************************************************
// reset values
// ****************************************************************
`define CEP_RESET_PEND_INIT 1'b1
`define CEP_SYNC_INIT 1'b0

`endif

// File: cep_pkg.sv
`default_nettype none

`include "cep_params.svh"

package cep_pkg;

  // ****************************************************************
  // exception causes, numbered in order of priority (0 wins)
  // ****************************************************************
  typedef enum logic [`CEP_CAUSE_W-1:0] {
    ec_reset = 5'h00,
    ec_debug_step = 5'h01,
    ec_debug_irq = 5'h02,
    ec_nmi = 5'h03,
    ec_irq = 5'h04,
    ec_instr_break_match = 5'h05,
    ec_addr_err_fetch = 5'h06,
    ec_fetch_bus_fault = 5'h07,
    ec_sw_debug_bkpt = 5'h08,
    ec_kernel_call = 5'h09,
    ec_breakpoint = 5'h0a,
    ec_reserved_opcode = 5'h0b,
    ec_cop_unusable = 5'h0c,
    ec_ext_op_disabled = 5'h0d,
    ec_arith_wrap = 5'h0e,
    ec_cond_check_fail = 5'h0f,
    ec_store_data_break = 5'h10,
    ec_addr_err_load = 5'h11,
    ec_addr_err_store = 5'h12,
    ec_data_bus_fault = 5'h13,
    ec_load_data_break = 5'h14
  } cep_cause_t;

  // ****************************************************************
  // core operating mode
  // ****************************************************************
  typedef enum logic [2:0] {
    st_run = 3'b001,
    st_debug = 3'b010,
    st_sleep = 3'b100
  } cep_mode_t;

endpackage

`default_nettype wire

// File: cep_prio_encoder.sv
`default_nettype none

module cep_prio_encoder #(
  parameter int N = 21,
  parameter int W = 5
) (
  input wire logic [N-1:0] req_i, // pending causes, bit 0 highest
  output logic valid_o, // any request pending
  output logic [W-1:0] index_o // index of the winning request
);

  // ****************************************************************
  // fixed-order search, lowest index wins
  // ****************************************************************
  always_comb
  begin
    valid_o = 1'b0;
    index_o = '0;
    for (int i = N - 1; i >= 0; i--)
    begin
      if (req_i[i])
      begin
        valid_o = 1'b1;
        index_o = W'(i);
      end
    end
  end

endmodule // cep_prio_encoder

`default_nettype wire

// File: cep_exception_unit.sv
`default_nettype none

`include "cep_params.svh"

module cep_exception_unit #(
  parameter int IRQ_W = `CEP_IRQ_W,
  parameter int COP_N = `CEP_COP_N
) (
  input wire logic mclk_i, // core clock
  input wire logic reset_n_i, // async reset, active low
  input wire logic master_clear_pin_n_i, // master clear, active low
  input wire logic por_i, // power-on reset event
  input wire logic debug_single_step_i, // single-step debugging active
  input wire logic ext_debug_irq_pin_i, // external debug interrupt
  input wire logic debug_break_req_bit_i, // break-request bit of debug_ctrl_reg
  input wire logic nmi_i, // non-maskable interrupt
  input wire logic [IRQ_W-1:0] irq_req_i, // hw and sw interrupt requests
  input wire logic [IRQ_W-1:0] irq_en_i, // per-request enable
  input wire logic irq_global_en_i, // global interrupt enable
  input wire logic instr_break_match_i, // instruction breakpoint hit
  input wire logic fetch_misalign_i, // fetch address misaligned
  input wire logic fetch_protect_i, // fetch to protected address
  input wire logic fetch_bus_fault_i, // bus error on fetch
  input wire logic sw_debug_bkpt_instr_i, // software debug breakpoint executed
  input wire logic kernel_call_instr_i, // kernel call executed
  input wire logic break_instr_i, // break instruction executed
  input wire logic reserved_opcode_i, // reserved encoding decoded
  input wire logic cop_instr_i, // coprocessor instruction executed
  input wire logic [`CEP_COP_SEL_W-1:0] cop_sel_i, // targeted coprocessor
  input wire logic [COP_N-1:0] cop_en_i, // coprocessor enables
  input wire logic ext_op_instr_i, // extension instruction executed
  input wire logic ext_op_en_i, // extension facility enabled
  input wire logic arith_wrap_i, // arithmetic overflow
  input wire logic trap_instr_i, // trap instruction executed
  input wire logic trap_cond_i, // trap condition true
  input wire logic data_addr_match_i, // data breakpoint address hit
  input wire logic data_value_mode_i, // data breakpoint also compares value
  input wire logic data_value_match_i, // data breakpoint value hit
  input wire logic load_i, // load in progress
  input wire logic store_i, // store in progress
  input wire logic data_misalign_i, // data address misaligned
  input wire logic data_protect_i, // data address protected
  input wire logic data_bus_fault_i, // bus error on load or store
  input wire logic load_data_valid_i, // load data returned
  input wire logic debug_return_instr_i, // debug return executed
  input wire logic wait_instr_i, // wait instruction executed
  output logic exc_valid_o, // exception taken this cycle
  output cep_pkg::cep_cause_t exc_code_o, // cause of the taken exception
  output logic exc_debug_o, // taken exception is a debug one
  output logic debug_mode_o, // core in debug mode
  output logic power_down_o // core in power-down mode
);

  // ****************************************************************
  // reset release
  // ****************************************************************
  logic rst_meta_reg;
  logic rst_sync_reg;

  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      rst_meta_reg <= `CEP_SYNC_INIT;
      rst_sync_reg <= `CEP_SYNC_INIT;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic is_debug_cause(input cep_pkg::cep_cause_t c);
    is_debug_cause = (c == cep_pkg::ec_debug_step) || (c == cep_pkg::ec_debug_irq) ||
                     (c == cep_pkg::ec_instr_break_match) ||
                     (c == cep_pkg::ec_sw_debug_bkpt) ||
                     (c == cep_pkg::ec_store_data_break) ||
                     (c == cep_pkg::ec_load_data_break);
  endfunction

  // ****************************************************************
  // cause collection
  // ****************************************************************
  cep_pkg::cep_mode_t mode_reg;
  cep_pkg::cep_mode_t mode_next;
  logic reset_pend_reg;
  logic in_debug;
  logic irq_pend;
  logic [`CEP_NUM_CAUSES-1:0] cause_vec;
  logic win_valid;
  logic [`CEP_CAUSE_W-1:0] win_index;
  cep_pkg::cep_cause_t win_code;

  assign in_debug = (mode_reg == cep_pkg::st_debug);
  // interrupts and async debug events are held off inside the debug handler
  assign irq_pend = irq_global_en_i && |(irq_req_i & irq_en_i);

  always_comb
  begin
    cause_vec = '0;
    cause_vec[cep_pkg::ec_reset] = reset_pend_reg || !master_clear_pin_n_i || por_i;
    cause_vec[cep_pkg::ec_debug_step] = debug_single_step_i && !in_debug;
    cause_vec[cep_pkg::ec_debug_irq] = (ext_debug_irq_pin_i || debug_break_req_bit_i) &&
                                       !in_debug;
    cause_vec[cep_pkg::ec_nmi] = nmi_i && !in_debug;
    cause_vec[cep_pkg::ec_irq] = irq_pend && !in_debug;
    cause_vec[cep_pkg::ec_instr_break_match] = instr_break_match_i && !in_debug;
    cause_vec[cep_pkg::ec_addr_err_fetch] = fetch_misalign_i || fetch_protect_i;
    cause_vec[cep_pkg::ec_fetch_bus_fault] = fetch_bus_fault_i;
    cause_vec[cep_pkg::ec_sw_debug_bkpt] = sw_debug_bkpt_instr_i;
    cause_vec[cep_pkg::ec_kernel_call] = kernel_call_instr_i;
    cause_vec[cep_pkg::ec_breakpoint] = break_instr_i;
    cause_vec[cep_pkg::ec_reserved_opcode] = reserved_opcode_i;
    cause_vec[cep_pkg::ec_cop_unusable] = cop_instr_i && !cop_en_i[cop_sel_i];
    cause_vec[cep_pkg::ec_ext_op_disabled] = ext_op_instr_i && !ext_op_en_i;
    cause_vec[cep_pkg::ec_arith_wrap] = arith_wrap_i;
    cause_vec[cep_pkg::ec_cond_check_fail] = trap_instr_i && trap_cond_i;
    cause_vec[cep_pkg::ec_store_data_break] = data_addr_match_i && !in_debug &&
      (load_i || store_i) &&
      (!data_value_mode_i || (store_i && data_value_match_i));
    cause_vec[cep_pkg::ec_addr_err_load] = load_i && (data_misalign_i || data_protect_i);
    cause_vec[cep_pkg::ec_addr_err_store] = store_i &&
                                            (data_misalign_i || data_protect_i);
    cause_vec[cep_pkg::ec_data_bus_fault] = data_bus_fault_i && (load_i || store_i);
    cause_vec[cep_pkg::ec_load_data_break] = data_addr_match_i && data_value_mode_i &&
      load_i && load_data_valid_i && data_value_match_i && !in_debug;
  end

  // ****************************************************************
  // fixed priority selection
  // ****************************************************************
  cep_prio_encoder #(
    .N(`CEP_NUM_CAUSES),
    .W(`CEP_CAUSE_W)
  ) u_prio (
    .req_i(cause_vec),
    .valid_o(win_valid),
    .index_o(win_index)
  );

  assign win_code = cep_pkg::cep_cause_t'(win_index);

  // ****************************************************************
  // reset exception pending after release
  // ****************************************************************
  always_ff @(posedge mclk_i or negedge rst_sync_reg)
  begin
    if (!rst_sync_reg)
      reset_pend_reg <= `CEP_RESET_PEND_INIT;
    else
      reset_pend_reg <= 1'b0;
  end

  // ****************************************************************
  // mode machine
  // ****************************************************************
  always_comb
  begin
    mode_next = mode_reg;
    unique case (mode_reg)
      cep_pkg::st_run:
      begin
        if (win_valid && is_debug_cause(win_code))
          mode_next = cep_pkg::st_debug;
        else if (!win_valid && wait_instr_i)
          mode_next = cep_pkg::st_sleep;
      end
      cep_pkg::st_debug:
      begin
        if (debug_return_instr_i)
          mode_next = cep_pkg::st_run;
      end
      cep_pkg::st_sleep:
      begin
        if (win_valid)
          mode_next = is_debug_cause(win_code) ? cep_pkg::st_debug : cep_pkg::st_run;
      end
      default:
        mode_next = cep_pkg::st_run;
    endcase
    if (win_valid && (win_code == cep_pkg::ec_reset))
      mode_next = cep_pkg::st_run;
  end

  always_ff @(posedge mclk_i or negedge rst_sync_reg)
  begin
    if (!rst_sync_reg)
      mode_reg <= cep_pkg::st_run;
    else
      mode_reg <= mode_next;
  end

  // ****************************************************************
  // registered outputs
  // ****************************************************************
  always_ff @(posedge mclk_i or negedge rst_sync_reg)
  begin
    if (!rst_sync_reg)
    begin
      exc_valid_o <= 1'b0;
      exc_code_o <= cep_pkg::ec_reset;
      exc_debug_o <= 1'b0;
    end
    else
    begin
      exc_valid_o <= win_valid;
      exc_code_o <= win_code;
      exc_debug_o <= win_valid && is_debug_cause(win_code);
    end
  end

  always_ff @(posedge mclk_i or negedge rst_sync_reg)
  begin
    if (!rst_sync_reg)
    begin
      debug_mode_o <= 1'b0;
      power_down_o <= 1'b0;
    end
    else
    begin
      debug_mode_o <= (mode_next == cep_pkg::st_debug);
      power_down_o <= (mode_next == cep_pkg::st_sleep);
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_sync_reg);

  sequence s_in_debug_return;
    debug_mode_o && debug_return_instr_i && !win_valid;
  endsequence

  sequence s_left_debug;
    !debug_mode_o && !exc_valid_o;
  endsequence

  AST_RESET_WINS: assert property (
    !master_clear_pin_n_i |=> exc_valid_o && (exc_code_o == cep_pkg::ec_reset))
    else $error("master clear did not raise reset exception");

  AST_STEP_BELOW_RESET: assert property (
    debug_single_step_i && !cause_vec[0] && !debug_mode_o && (mode_reg != cep_pkg::st_debug)
    |=> exc_code_o == cep_pkg::ec_debug_step)
    else $error("single step not taken below reset");

  AST_NMI_OVER_IRQ: assert property (
    cause_vec[cep_pkg::ec_nmi] && cause_vec[2:0] == 3'h0
    |=> exc_valid_o && (exc_code_o == cep_pkg::ec_nmi))
    else $error("nmi lost to lower cause");

  AST_MASKED_IRQ_QUIET: assert property (
    (cause_vec & ~(`CEP_NUM_CAUSES'(1) << cep_pkg::ec_irq)) == '0 && !irq_pend
    |=> !exc_valid_o)
    else $error("exception raised with only masked interrupts");

  AST_FETCH_ORDER: assert property (
    fetch_misalign_i && fetch_bus_fault_i && cause_vec[5:0] == 6'h00
    |=> exc_code_o == cep_pkg::ec_addr_err_fetch)
    else $error("fetch bus fault beat fetch address error");

  AST_TRAP_FALSE: assert property (
    trap_instr_i && !trap_cond_i && (cause_vec == '0) |=> !exc_valid_o)
    else $error("trap taken with false condition");

  // a debug return in the same cycle as a debug breakpoint still leaves debug mode
  AST_DEBUG_ENTRY: assert property (
    exc_valid_o && exc_debug_o && !($past(debug_mode_o) && $past(debug_return_instr_i))
    |-> debug_mode_o)
    else $error("debug exception did not enter debug mode");

  AST_DEBUG_HOLD: assert property (
    debug_mode_o && !debug_return_instr_i && !cause_vec[0] |=> debug_mode_o [*1])
    else $error("debug mode left without debug return");

  AST_DEBUG_EXIT: assert property (
    s_in_debug_return |=> s_left_debug)
    else $error("debug return did not leave debug mode");

  AST_WAIT_SLEEPS: assert property (
    !debug_mode_o && !power_down_o && wait_instr_i && !win_valid
    |=> power_down_o ##1 (power_down_o || $past(win_valid)))
    else $error("wait did not enter power down");

endmodule // cep_exception_unit

`default_nettype wire

// File: cep_far_side.sv
`default_nettype none

// ********
// far side: pipeline, interrupt controller and debug logic
// ********
module cep_far_side (
  input wire logic [20:0] cause_i, // causes to present, bit k raises cause k
  input wire logic [31:0] rnd_i, // picks among equal ways to raise a cause
  output logic master_clear_pin_n_o, // master clear, active low
  output logic por_o, // power-on reset
  output logic debug_single_step_o, // single step active
  output logic ext_debug_irq_pin_o, // external debug interrupt
  output logic debug_break_req_bit_o, // break-request bit
  output logic nmi_o, // non-maskable interrupt
  output logic irq_global_en_o, // global interrupt enable
  output logic [7:0] irq_req_o, // interrupt requests
  output logic [7:0] irq_en_o, // interrupt enables
  output logic instr_break_match_o, // instruction breakpoint hit
  output logic fetch_misalign_o, // fetch misaligned
  output logic fetch_protect_o, // fetch protected
  output logic fetch_bus_fault_o, // fetch bus error
  output logic sw_debug_bkpt_instr_o, // software debug breakpoint
  output logic kernel_call_instr_o, // kernel call
  output logic break_instr_o, // break instruction
  output logic reserved_opcode_o, // reserved encoding
  output logic cop_instr_o, // coprocessor instruction
  output logic [1:0] cop_sel_o, // coprocessor target
  output logic [3:0] cop_en_o, // coprocessor enables
  output logic ext_op_instr_o, // extension instruction
  output logic ext_op_en_o, // extension facility on
  output logic arith_wrap_o, // overflow
  output logic trap_instr_o, // trap instruction
  output logic trap_cond_o, // trap condition
  output logic data_addr_match_o, // data break address hit
  output logic data_value_mode_o, // data break compares value
  output logic data_value_match_o, // data break value hit
  output logic load_o, // load
  output logic store_o, // store
  output logic data_misalign_o, // data misaligned
  output logic data_protect_o, // data protected
  output logic data_bus_fault_o, // data bus error
  output logic load_data_valid_o // load data returned
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] irq_pick;
  logic [3:0] cop_pick;

  assign irq_pick = 8'h01 << rnd_i[6:4];
  assign cop_pick = 4'h1 << rnd_i[26:25];

  // the inactive interrupt, coprocessor, extension, trap and data break causes still toggle their qualifiers at random
  always_comb
  begin
    master_clear_pin_n_o = !(cause_i[0] && rnd_i[0]);
    por_o = cause_i[0] && !rnd_i[0];
    debug_single_step_o = cause_i[1];
    ext_debug_irq_pin_o = cause_i[2] && rnd_i[1];
    debug_break_req_bit_o = cause_i[2] && !rnd_i[1];
    nmi_o = cause_i[3];
    irq_global_en_o = cause_i[4] || rnd_i[2];
    irq_req_o = rnd_i[15:8] | (cause_i[4] ? irq_pick : 8'h00);
    irq_en_o = rnd_i[2] ? ~rnd_i[15:8] : rnd_i[23:16];
    if (cause_i[4])
      irq_en_o = rnd_i[23:16] | irq_pick;
    instr_break_match_o = cause_i[5];
    fetch_misalign_o = cause_i[6] && rnd_i[3];
    fetch_protect_o = cause_i[6] && !rnd_i[3];
    fetch_bus_fault_o = cause_i[7];
    sw_debug_bkpt_instr_o = cause_i[8];
    kernel_call_instr_o = cause_i[9];
    break_instr_o = cause_i[10];
    reserved_opcode_o = cause_i[11];
    cop_instr_o = cause_i[12] || rnd_i[24];
    cop_sel_o = rnd_i[26:25];
    cop_en_o = cause_i[12] ? (rnd_i[30:27] & ~cop_pick) : (rnd_i[30:27] | cop_pick);
    ext_op_instr_o = cause_i[13] || rnd_i[7];
    ext_op_en_o = !cause_i[13];
    arith_wrap_o = cause_i[14];
    trap_instr_o = cause_i[15] || rnd_i[31];
    trap_cond_o = cause_i[15] || !rnd_i[31];
    data_addr_match_o = cause_i[16] || cause_i[20];
    data_value_mode_o = (cause_i[16] && rnd_i[13]) || cause_i[20];
    data_value_match_o = data_value_mode_o || rnd_i[11];
    store_o = (cause_i[16] && rnd_i[13]) || cause_i[18] || (cause_i[19] && !rnd_i[13]);
    load_o = !store_o && ((|cause_i[20:16]) || rnd_i[9]);
    data_misalign_o = (cause_i[17] || cause_i[18]) && rnd_i[14];
    data_protect_o = (cause_i[17] || cause_i[18]) && !rnd_i[14];
    data_bus_fault_o = cause_i[19];
    load_data_valid_o = cause_i[20] || rnd_i[12];
  end
endmodule // cep_far_side

`default_nettype wire

// File: tb_top.sv
`default_nettype none

`define CHK(nm, ex, got) \
  begin \
    n_tests++; \
    if ((got) !== (ex)) \
    begin \
      n_mismatch++; \
      $display("BAD %s expected %h seen %h", nm, ex, got); \
    end \
  end

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [20:0] DBG_MASK = 21'h11003e;
  localparam logic [20:0] DBG_SET = 21'h110126;
  logic mclk_i, reset_n_i, master_clear_pin_n_i, por_i, debug_single_step_i;
  logic ext_debug_irq_pin_i, debug_break_req_bit_i, nmi_i, irq_global_en_i;
  logic [7:0] irq_req_i, irq_en_i;
  logic instr_break_match_i, fetch_misalign_i, fetch_protect_i, fetch_bus_fault_i;
  logic sw_debug_bkpt_instr_i, kernel_call_instr_i, break_instr_i, reserved_opcode_i;
  logic cop_instr_i, ext_op_instr_i, ext_op_en_i, arith_wrap_i, trap_instr_i, trap_cond_i;
  logic [1:0] cop_sel_i;
  logic [3:0] cop_en_i;
  logic data_addr_match_i, data_value_mode_i, data_value_match_i, load_i, store_i;
  logic data_misalign_i, data_protect_i, data_bus_fault_i, load_data_valid_i;
  logic debug_return_instr_i, wait_instr_i, exc_valid_o, exc_debug_o, debug_mode_o;
  logic power_down_o, go, seen, e_valid, e_dbg;
  cep_pkg::cep_cause_t exc_code_o, e_code;
  cep_pkg::cep_mode_t m_mode;
  logic [20:0] cause_i, pend;
  logic [31:0] rnd_i, seed;
  int n_tests, n_mismatch, cyc, w, wr;

  cep_exception_unit cep_exception_unit_inst (
    .mclk_i(mclk_i),
    .reset_n_i(reset_n_i),
    .master_clear_pin_n_i(master_clear_pin_n_i),
    .por_i(por_i),
    .debug_single_step_i(debug_single_step_i),
    .ext_debug_irq_pin_i(ext_debug_irq_pin_i),
    .debug_break_req_bit_i(debug_break_req_bit_i),
    .nmi_i(nmi_i),
    .irq_req_i(irq_req_i),
    .irq_en_i(irq_en_i),
    .irq_global_en_i(irq_global_en_i),
    .instr_break_match_i(instr_break_match_i),
    .fetch_misalign_i(fetch_misalign_i),
    .fetch_protect_i(fetch_protect_i),
    .fetch_bus_fault_i(fetch_bus_fault_i),
    .sw_debug_bkpt_instr_i(sw_debug_bkpt_instr_i),
    .kernel_call_instr_i(kernel_call_instr_i),
    .break_instr_i(break_instr_i),
    .reserved_opcode_i(reserved_opcode_i),
    .cop_instr_i(cop_instr_i),
    .cop_sel_i(cop_sel_i),
    .cop_en_i(cop_en_i),
    .ext_op_instr_i(ext_op_instr_i),
    .ext_op_en_i(ext_op_en_i),
    .arith_wrap_i(arith_wrap_i),
    .trap_instr_i(trap_instr_i),
    .trap_cond_i(trap_cond_i),
    .data_addr_match_i(data_addr_match_i),
    .data_value_mode_i(data_value_mode_i),
    .data_value_match_i(data_value_match_i),
    .load_i(load_i),
    .store_i(store_i),
    .data_misalign_i(data_misalign_i),
    .data_protect_i(data_protect_i),
    .data_bus_fault_i(data_bus_fault_i),
    .load_data_valid_i(load_data_valid_i),
    .debug_return_instr_i(debug_return_instr_i),
    .wait_instr_i(wait_instr_i),
    .exc_valid_o(exc_valid_o),
    .exc_code_o(exc_code_o),
    .exc_debug_o(exc_debug_o),
    .debug_mode_o(debug_mode_o),
    .power_down_o(power_down_o)
  );

  cep_far_side cep_far_side_inst (
    .cause_i(cause_i),
    .rnd_i(rnd_i),
    .master_clear_pin_n_o(master_clear_pin_n_i),
    .por_o(por_i),
    .debug_single_step_o(debug_single_step_i),
    .ext_debug_irq_pin_o(ext_debug_irq_pin_i),
    .debug_break_req_bit_o(debug_break_req_bit_i),
    .nmi_o(nmi_i),
    .irq_global_en_o(irq_global_en_i),
    .irq_req_o(irq_req_i),
    .irq_en_o(irq_en_i),
    .instr_break_match_o(instr_break_match_i),
    .fetch_misalign_o(fetch_misalign_i),
    .fetch_protect_o(fetch_protect_i),
    .fetch_bus_fault_o(fetch_bus_fault_i),
    .sw_debug_bkpt_instr_o(sw_debug_bkpt_instr_i),
    .kernel_call_instr_o(kernel_call_instr_i),
    .break_instr_o(break_instr_i),
    .reserved_opcode_o(reserved_opcode_i),
    .cop_instr_o(cop_instr_i),
    .cop_sel_o(cop_sel_i),
    .cop_en_o(cop_en_i),
    .ext_op_instr_o(ext_op_instr_i),
    .ext_op_en_o(ext_op_en_i),
    .arith_wrap_o(arith_wrap_i),
    .trap_instr_o(trap_instr_i),
    .trap_cond_o(trap_cond_i),
    .data_addr_match_o(data_addr_match_i),
    .data_value_mode_o(data_value_mode_i),
    .data_value_match_o(data_value_match_i),
    .load_o(load_i),
    .store_o(store_i),
    .data_misalign_o(data_misalign_i),
    .data_protect_o(data_protect_i),
    .data_bus_fault_o(data_bus_fault_i),
    .load_data_valid_o(load_data_valid_i)
  );

  // ********
  // helpers
  // ********
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // only the highest ranked data-stage cause can be presented at once
  function automatic logic [20:0] trim(input logic [20:0] v);
    for (int i = 16; i < 21; i++)
      if (v[i])
        return v & ~(21'h1fffff << (i + 1));
    return v;
  endfunction

  function automatic int first_set(input logic [20:0] v);
    for (int i = 0; i < 21; i++)
      if (v[i])
        return i;
    return 0;
  endfunction

  task automatic step(input logic [20:0] c, input logic ret, input logic wt);
    @(posedge mclk_i);
    cause_i <= trim(c);
    rnd_i <= rnd();
    debug_return_instr_i <= ret;
    wait_instr_i <= wt;
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // ********
  // reference model and checks
  // ********
  always @(posedge mclk_i)
  begin
    if (go)
    begin
      pend = cause_i & ((m_mode == cep_pkg::st_debug) ? ~DBG_MASK : 21'h1fffff);
      w = first_set(pend);
      e_valid = |pend;
      e_code = cep_pkg::cep_cause_t'(w);
      e_dbg = DBG_SET[w];
      if (pend[0] || (m_mode == cep_pkg::st_debug && debug_return_instr_i))
        m_mode = cep_pkg::st_run;
      else if (m_mode != cep_pkg::st_debug && e_valid)
        m_mode = e_dbg ? cep_pkg::st_debug : cep_pkg::st_run;
      else if (m_mode == cep_pkg::st_run && wait_instr_i)
        m_mode = cep_pkg::st_sleep;
      seen = 1'b1;
    end
  end

  always @(negedge mclk_i)
  begin
    if (seen)
    begin
      `CHK("exc_valid", e_valid, exc_valid_o)
      if (e_valid)
      begin
        `CHK("exc_code", e_code, exc_code_o)
        `CHK("exc_debug", e_dbg, exc_debug_o)
      end
      `CHK("debug_mode", m_mode == cep_pkg::st_debug, debug_mode_o)
      `CHK("power_down", m_mode == cep_pkg::st_sleep, power_down_o)
    end
  end

  always @(posedge mclk_i)
  begin
    cyc++;
    if (cyc == 10000)
    begin
      n_mismatch++;
      results();
    end
  end

  initial
  begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end

  // ********
  // stimulus
  // ********
  initial
  begin
    {reset_n_i, go, seen, debug_return_instr_i, wait_instr_i} = '0;
    {cause_i, rnd_i, n_tests, n_mismatch, cyc} = '0;
    seed = 32'h30da;
    m_mode = cep_pkg::st_run;
    repeat (8) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    for (int i = 0; i < 10 && exc_valid_o !== 1'b1; i++)
      @(negedge mclk_i);
    `CHK("reset_valid", 1'b1, exc_valid_o)
    `CHK("reset_cause", cep_pkg::ec_reset, exc_code_o)
    go = 1'b1;
    for (int k = 0; k < 21; k++)
    begin
      step(21'h1 << k, 1'b0, 1'b0);
      step('0, 1'b1, 1'b0);
      @(negedge mclk_i);
      `CHK("single", cep_pkg::cep_cause_t'(k), exc_code_o)
      step(21'h1fffff << k, 1'b0, 1'b0);
      step('0, 1'b1, 1'b0);
      @(negedge mclk_i);
      `CHK("ranked", cep_pkg::cep_cause_t'(k), exc_code_o)
      step('0, 1'b0, 1'b0);
    end
    $display("test single and ranked causes done");
    step(21'h100, 1'b0, 1'b0);
    step(21'h1ffffe, 1'b0, 1'b1);
    step(21'h200, 1'b1, 1'b0);
    step(21'h100, 1'b0, 1'b0);
    step(21'h1, 1'b0, 1'b0);
    step('0, 1'b0, 1'b1);
    repeat (4) step('0, 1'b0, 1'b0);
    step(21'h10, 1'b0, 1'b0);
    step(21'h200, 1'b0, 1'b1);
    step('0, 1'b0, 1'b1);
    step(21'h4, 1'b0, 1'b0);
    step('0, 1'b1, 1'b0);
    $display("test debug and power-down corners done");
    repeat (3000)
    begin
      wr = rnd();
      step(21'(rnd() & rnd() & rnd() & 32'h1ffffe) | 21'(wr[7:0] == 8'h00), &wr[9:8],
           &wr[11:10]);
    end
    step('0, 1'b1, 1'b0);
    repeat (2) step('0, 1'b0, 1'b0);
    $display("test random traffic done");
    results();
  end
endmodule // tb_top

`default_nettype wire
